// ### hw/modem_capture.sv
// Modem input synchroniser, status levels and change flags
`timescale 1ns/100ps
module modem_capture
  import uart_msi_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic [3:0] pins_n_i,
  modem_status_if.capture ms
);

  logic [3:0] meta_n;
  logic [3:0] sync_n;
  logic [3:0] prev_src;
  logic [3:0] src;
  logic [3:0] cur;

  // Source level as seen on the pin, or the control bit in loop-back
  always_comb begin
    src = ms.loopback ? ms.loop_src : sync_n;
    cur = ms.loopback ? ms.loop_src : ~sync_n;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_n <= PIN_IDLE_N;
      sync_n <= PIN_IDLE_N;
    end else if (clk_en_i) begin
      meta_n <= pins_n_i;
      sync_n <= meta_n;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev_src   <= PIN_IDLE_N;
      ms.status  <= 4'h0;
      ms.cts_off <= 1'b0;
    end else if (clk_en_i) begin
      prev_src   <= src;
      ms.status  <= cur;
      ms.cts_off <= ms.status[MS_CTS] & ~cur[MS_CTS];
    end
  end

  // New change wins over a clearing read in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ms.delta <= 4'h0;
    end else if (clk_en_i) begin
      for (int i = 0; i < 4; i++) begin
        if (i == MS_RI) begin
          ms.delta[i] <= (~prev_src[i] & src[i]) | (ms.delta[i] & ~ms.clear);
        end else begin
          ms.delta[i] <= (prev_src[i] ^ src[i]) | (ms.delta[i] & ~ms.clear);
        end
      end
    end
  end

  property p_status_normal;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && !ms.loopback) |=> (ms.status == ~$past(sync_n));
  endproperty
  a_status_normal: assert property (p_status_normal) else $error("status not pin complement");

  property p_status_loop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && ms.loopback) |=> (ms.status == $past(ms.loop_src));
  endproperty
  a_status_loop: assert property (p_status_loop) else $error("status not loop source");

  property p_delta_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && (((prev_src ^ src) & 4'hB) != 4'h0))
      |=> ((ms.delta & $past((prev_src ^ src) & 4'hB)) == $past((prev_src ^ src) & 4'hB));
  endproperty
  a_delta_set: assert property (p_delta_set) else $error("change flag missed");

  property p_ri_fall;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && prev_src[MS_RI] && !src[MS_RI] && !ms.delta[MS_RI]) |=> !ms.delta[MS_RI];
  endproperty
  a_ri_fall: assert property (p_ri_fall) else $error("ring flag set on wrong edge");

  property p_read_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && ms.clear && (prev_src == src)) |=> (ms.delta == 4'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

endmodule

// ### hw/uart_modem_status_and_interrupts.sv
// Modem status, interrupt enables and prioritised source identification for one channel
//
// Contract
// - Normal mode: status bits 7..4 are inverted carrier, ring, dsr, cts pins.
// - Loop-back: status bits follow control bits 3, 2, 0, 1.
// - Carrier, dsr, cts change flags set on either edge of source.
// - Ring change flag sets only on source low-to-high.
// - Reading modem status returns then clears all four change flags.
// - Enable bits 0..3 gate rx-data, tx-holding, line status, modem; reset off.
// - Enable bits 7, 6, 5 gate cts, rts and flow-stop interrupts; reset off.
// - Enable bit 4 requests sleep mode; zero keeps channel awake.
// - Enable bits 7..4 writable only while enhanced bit 4 set.
// - Re-enabling tx-holding interrupt gives no new interrupt while below threshold.
// - Interrupt output active while any enabled source pends.
// - Identification register read-only; bit 0 low when pending.
// - Identification bits 7, 6 mirror fifo enable bit 0.
// - Id bit 4 flags flow-stop character; bit 5 rts/cts change.
// - Only highest priority source reported; lower ones held back.
// - Line status 000110 first; timeout 001100, rx-data 000100 second.
// - Tx-holding 000010 third; modem 000000 fourth.
// - Flow-stop 010000 fifth; rts/cts going inactive 100000 sixth.
// - Control bit 4 selects internal loop-back, including tx to rx.
// - Enhanced bit 4 unlocks enable 7..4, fifo 5..4, control 7..5.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
module uart_modem_status_and_interrupts
  import uart_msi_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              cd_n_i,
  input  wire logic              ri_n_i,
  input  wire logic              dsr_n_i,
  input  wire logic              cts_n_i,
  input  wire logic              rts_n_i,
  input  wire logic              line_err_i,
  input  wire logic              rx_timeout_i,
  input  wire logic              rx_ready_i,
  input  wire logic              tx_low_i,
  input  wire logic              tx_write_i,
  input  wire logic              xoff_det_i,
  output logic                   irq_o,
  output logic                   sleep_req_o,
  output logic                   loopback_o,
  output logic      [7:0]        modem_ctrl_o,
  output logic      [7:0]        fifo_ctrl_o,
  output logic      [7:0]        enh_feature_o
);

  logic [7:0] interrupt_enables;
  logic [7:0] modem_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] fifo_control_reg;
  logic       thr_flag;
  logic       tx_low_prev;
  logic       xoff_flag;
  logic       cts_flag;
  logic       rts_flag;
  logic       rts_prev;
  logic [6:0] pend;
  logic [5:0] cur_id;
  logic       any_pending;
  logic       wr_en;
  logic       rd_en;
  logic       iir_rd;
  logic       unlock;

  modem_status_if ms ();

  assign wr_en  = clk_en_i & wr_i;
  assign rd_en  = clk_en_i & rd_i;
  assign iir_rd = rd_en && (addr_i == ADDR_IIR);
  assign unlock = enhanced_feature_reg[EF_ENH];

  assign ms.loopback = modem_control_reg[MC_LOOP];
  assign ms.loop_src = {modem_control_reg[MC_IRQEN], modem_control_reg[MC_FIFORDY],
                        modem_control_reg[MC_DTR], modem_control_reg[MC_RTS]};
  assign ms.clear    = rd_en && (addr_i == ADDR_MSR);

  modem_capture u_capture (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .pins_n_i  ({cd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .ms        (ms.capture)
  );

  // Register writes; protected fields keep their value while locked
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      interrupt_enables <= IER_RST;
    end else if (wr_en && (addr_i == ADDR_IER)) begin
      interrupt_enables <= protected_write(interrupt_enables, wdata_i,
                                           IER_PROT_MASK, unlock);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      modem_control_reg <= MCR_RST;
    end else if (wr_en && (addr_i == ADDR_MCR)) begin
      modem_control_reg <= protected_write(modem_control_reg, wdata_i,
                                           MCR_PROT_MASK, unlock);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_control_reg <= FCR_RST;
    end else if (wr_en && (addr_i == ADDR_FCR)) begin
      fifo_control_reg <= protected_write(fifo_control_reg, wdata_i,
                                          FCR_PROT_MASK, unlock);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      enhanced_feature_reg <= EFR_RST;
    end else if (wr_en && (addr_i == ADDR_EFR)) begin
      enhanced_feature_reg <= wdata_i;
    end
  end

  // Tx-holding source is an edge into the below-threshold state, so that
  // a later re-enable finds no edge and stays quiet
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_low_prev <= 1'b0;
      thr_flag    <= 1'b0;
    end else if (clk_en_i) begin
      tx_low_prev <= tx_low_i;
      if (!interrupt_enables[IE_THR]) begin
        thr_flag <= 1'b0;
      end else if (tx_low_i && !tx_low_prev) begin
        thr_flag <= 1'b1;
      end else if (tx_write_i || (iir_rd && (cur_id == ID_THR))) begin
        thr_flag <= 1'b0;
      end
    end
  end

  // Flow-stop character flag, cleared when its identification is read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      xoff_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (xoff_det_i) begin
        xoff_flag <= 1'b1;
      end else if (iir_rd && (cur_id == ID_XOFF)) begin
        xoff_flag <= 1'b0;
      end
    end
  end

  // Rts or cts going to the inactive level
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rts_prev <= 1'b1;
      rts_flag <= 1'b0;
      cts_flag <= 1'b0;
    end else if (clk_en_i) begin
      rts_prev <= rts_n_i;
      if (rts_n_i && !rts_prev) begin
        rts_flag <= 1'b1;
      end else if (iir_rd && (cur_id == ID_CTSRTS)) begin
        rts_flag <= 1'b0;
      end
      if (ms.cts_off) begin
        cts_flag <= 1'b1;
      end else if (iir_rd && (cur_id == ID_CTSRTS)) begin
        cts_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    pend[0] = interrupt_enables[IE_RLS] & line_err_i;
    pend[1] = interrupt_enables[IE_RHR] & rx_timeout_i;
    pend[2] = interrupt_enables[IE_RHR] & rx_ready_i;
    pend[3] = thr_flag;
    pend[4] = interrupt_enables[IE_MODEM] & (|ms.delta);
    pend[5] = interrupt_enables[IE_XOFF] & xoff_flag;
    pend[6] = (interrupt_enables[IE_CTS] & cts_flag)
            | (interrupt_enables[IE_RTS] & rts_flag);
    cur_id      = pick_id(pend);
    any_pending = |pend;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= any_pending;
    end
  end

  // Read data stand one cycle; zero otherwise and for unmapped offsets.
  // The id register has no write path at all.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (!rd_i) begin
        rdata_o <= 8'h00;
      end else if (addr_i == ADDR_IER) begin
        rdata_o <= interrupt_enables;
      end else if (addr_i == ADDR_IIR) begin
        rdata_o <= {{2{fifo_control_reg[FC_EN]}}, cur_id};
      end else if (addr_i == ADDR_MCR) begin
        rdata_o <= modem_control_reg;
      end else if (addr_i == ADDR_EFR) begin
        rdata_o <= enhanced_feature_reg;
      end else if (addr_i == ADDR_FCR) begin
        rdata_o <= fifo_control_reg;
      end else if (addr_i == ADDR_MSR) begin
        rdata_o <= {ms.status, ms.delta};
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  always_comb begin
    sleep_req_o   = interrupt_enables[IE_SLEEP];
    loopback_o    = modem_control_reg[MC_LOOP];
    modem_ctrl_o  = modem_control_reg;
    fifo_ctrl_o   = fifo_control_reg;
    enh_feature_o = enhanced_feature_reg;
  end

  property p_ier_lock;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_en && (addr_i == ADDR_IER) && !unlock)
      |=> (interrupt_enables[7:4] == $past(interrupt_enables[7:4]))
          && (interrupt_enables[3:0] == $past(wdata_i[3:0]));
  endproperty
  a_ier_lock: assert property (p_ier_lock) else $error("locked enable bits changed");

  property p_sleep;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_en && (addr_i == ADDR_IER) && unlock) |=> (sleep_req_o == $past(wdata_i[IE_SLEEP]));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request wrong");

  property p_thr_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && tx_low_prev && tx_low_i && !thr_flag) |=> !thr_flag;
  endproperty
  a_thr_quiet: assert property (p_thr_quiet) else $error("tx interrupt without edge");

  property p_irq_rls;
    @(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && interrupt_enables[IE_RLS] && line_err_i) |=> irq_o;
  endproperty
  a_irq_rls: assert property (p_irq_rls) else $error("interrupt output not raised");

  property p_iir_none;
    @(posedge sys_clk_i) disable iff (rst_i)
    (iir_rd && !any_pending) |=> (rdata_o[5:0] == ID_NONE) && !irq_o;
  endproperty
  a_iir_none: assert property (p_iir_none) else $error("idle id wrong");

  property p_iir_fifo;
    @(posedge sys_clk_i) disable iff (rst_i)
    iir_rd |=> (rdata_o[7:6] == {2{$past(fifo_control_reg[FC_EN])}});
  endproperty
  a_iir_fifo: assert property (p_iir_fifo) else $error("fifo mirror bits wrong");

  property p_iir_top;
    @(posedge sys_clk_i) disable iff (rst_i)
    (iir_rd && pend[0]) |=> (rdata_o[5:0] == ID_RLS) && irq_o;
  endproperty
  a_iir_top: assert property (p_iir_top) else $error("line status not top priority");

  property p_modem_pend;
    @(posedge sys_clk_i) disable iff (rst_i)
    (iir_rd && interrupt_enables[IE_MODEM] && (ms.delta != 4'h0) && (pend[3:0] == 4'h0))
      |=> (rdata_o[5:0] == ID_MODEM);
  endproperty
  a_modem_pend: assert property (p_modem_pend) else $error("modem source not reported");

  property p_msr_value;
    @(posedge sys_clk_i) disable iff (rst_i)
    ms.clear |=> (rdata_o == $past({ms.status, ms.delta}));
  endproperty
  a_msr_value: assert property (p_msr_value) else $error("status read value wrong");

endmodule

// ### shared/modem_status_if.sv
// Link between the interrupt core and the modem status capture
`timescale 1ns/100ps
interface modem_status_if;
  logic       loopback;
  logic [3:0] loop_src;
  logic       clear;
  logic [3:0] status;
  logic [3:0] delta;
  logic       cts_off;

  modport capture (
    input  loopback,
    input  loop_src,
    input  clear,
    output status,
    output delta,
    output cts_off
  );

  modport core (
    output loopback,
    output loop_src,
    output clear,
    input  status,
    input  delta,
    input  cts_off
  );
endinterface

// ### shared/uart_msi_pkg.sv
// Constants, register map and helper functions of the modem status and interrupt block
package uart_msi_pkg;

  localparam int ADDR_W = 3;

  // Register byte offsets on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_IER = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_IIR = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_MCR = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_EFR = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_FCR = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_MSR = 3'h5;

  // Interrupt enable bit positions
  localparam int IE_RHR   = 0;
  localparam int IE_THR   = 1;
  localparam int IE_RLS   = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF  = 5;
  localparam int IE_RTS   = 6;
  localparam int IE_CTS   = 7;

  // Modem control bit positions
  localparam int MC_DTR     = 0;
  localparam int MC_RTS     = 1;
  localparam int MC_FIFORDY = 2;
  localparam int MC_IRQEN   = 3;
  localparam int MC_LOOP    = 4;

  localparam int EF_ENH = 4;
  localparam int FC_EN  = 0;

  // Modem line index: delta bit i, status bit i+4
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RI  = 2;
  localparam int MS_CD  = 3;

  // Bits writable only while the enhanced enable is set
  localparam logic [7:0] IER_PROT_MASK = 8'hF0;
  localparam logic [7:0] MCR_PROT_MASK = 8'hE0;
  localparam logic [7:0] FCR_PROT_MASK = 8'h30;

  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [3:0] PIN_IDLE_N = 4'hF;

  // Source identification, bits 5 to 0
  localparam logic [5:0] ID_NONE   = 6'h01;
  localparam logic [5:0] ID_RLS    = 6'h06;
  localparam logic [5:0] ID_RXTO   = 6'h0C;
  localparam logic [5:0] ID_RHR    = 6'h04;
  localparam logic [5:0] ID_THR    = 6'h02;
  localparam logic [5:0] ID_MODEM  = 6'h00;
  localparam logic [5:0] ID_XOFF   = 6'h10;
  localparam logic [5:0] ID_CTSRTS = 6'h20;

  function automatic logic [7:0] protected_write(input logic [7:0] old_val,
                                                 input logic [7:0] new_val,
                                                 input logic [7:0] mask,
                                                 input logic       unlock);
    protected_write = unlock ? new_val : ((old_val & mask) | (new_val & ~mask));
  endfunction

  // Pending vector, highest priority in bit 0
  function automatic logic [5:0] pick_id(input logic [6:0] pend);
    if (pend[0]) begin
      pick_id = ID_RLS;
    end else if (pend[1]) begin
      pick_id = ID_RXTO;
    end else if (pend[2]) begin
      pick_id = ID_RHR;
    end else if (pend[3]) begin
      pick_id = ID_THR;
    end else if (pend[4]) begin
      pick_id = ID_MODEM;
    end else if (pend[5]) begin
      pick_id = ID_XOFF;
    end else if (pend[6]) begin
      pick_id = ID_CTSRTS;
    end else begin
      pick_id = ID_NONE;
    end
  endfunction

endpackage

// ### sim/host_bus.sv
// Host processor model: register bus master that notes each read expectation
`timescale 1ns/100ps
module host_bus
  import uart_msi_pkg::*;
(
  input  wire logic              sys_clk_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [7:0]        wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  logic [7:0] exp_q[$];
  string      name_q[$];

  initial begin
    addr_o  = '0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // Leading edge wait keeps a strobe from being set and cleared in one step
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk_i);
    exp_q.push_back(e);
    name_q.push_back(n);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the modem status and interrupt block
`timescale 1ns/100ps
module tb;
  import uart_msi_pkg::*;
  logic              sys_clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              wr;
  logic              rd;
  logic [7:0]        rdata;
  logic [3:0]        pins_n;
  logic              rts_n;
  logic              line_err;
  logic              rx_timeout;
  logic              rx_ready;
  logic              tx_low;
  logic              xoff_det;
  logic              irq;
  logic              sleep_req;
  logic              loopback;
  logic [7:0]        modem_ctrl;
  logic [7:0]        fifo_ctrl;
  logic [7:0]        enh_feature;
  logic              rd_seen;
  logic [3:0]        src;
  logic [3:0]        dlt;
  int                mismatches;
  int                n_compared;

  host_bus host (
    .sys_clk_i (sys_clk_i),
    .addr_o    (addr),
    .wdata_o   (wdata),
    .wr_o      (wr),
    .rd_o      (rd)
  );

  uart_modem_status_and_interrupts DUT (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .clk_en_i      (1'b1),
    .addr_i        (addr),
    .wdata_i       (wdata),
    .wr_i          (wr),
    .rd_i          (rd),
    .rdata_o       (rdata),
    .cd_n_i        (pins_n[3]),
    .ri_n_i        (pins_n[2]),
    .dsr_n_i       (pins_n[1]),
    .cts_n_i       (pins_n[0]),
    .rts_n_i       (rts_n),
    .line_err_i    (line_err),
    .rx_timeout_i  (rx_timeout),
    .rx_ready_i    (rx_ready),
    .tx_low_i      (tx_low),
    .tx_write_i    (1'b0),
    .xoff_det_i    (xoff_det),
    .irq_o         (irq),
    .sleep_req_o   (sleep_req),
    .loopback_o    (loopback),
    .modem_ctrl_o  (modem_ctrl),
    .fifo_ctrl_o   (fifo_ctrl),
    .enh_feature_o (enh_feature)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i) rd_seen <= rd;
  always @(negedge sys_clk_i) begin
    if (rd_seen === 1'b1 && host.exp_q.size() > 0) begin
      check(host.name_q.pop_front(), host.exp_q.pop_front(), rdata);
    end
  end

  task automatic irq_expect(input logic e);
    @(negedge sys_clk_i);
    check("irq_o", {7'h00, e}, {7'h00, irq});
  endtask

  task automatic id_expect(input logic [5:0] id);
    repeat (2) @(posedge sys_clk_i);
    host.read_reg(ADDR_IIR, {2'b11, id}, "interrupt_source_id");
  endtask

  // New active-high source levels: cd, ri, dsr, cts
  task automatic modem_step(input logic [3:0] s, input logic lb);
    dlt[3] |= s[3] ^ src[3];
    dlt[1] |= s[1] ^ src[1];
    dlt[0] |= s[0] ^ src[0];
    dlt[2] |= lb ? (s[2] & ~src[2]) : (src[2] & ~s[2]);
    src = s;
    if (lb) begin
      pins_n <= 4'($urandom);
      host.write_reg(ADDR_MCR, {4'b0001, s[3], s[2], s[0], s[1]});
    end else begin
      @(posedge sys_clk_i);
      pins_n <= ~s;
    end
    repeat (6) @(negedge sys_clk_i);
    check("irq_o", {7'h00, |dlt}, {7'h00, irq});
    host.read_reg(ADDR_MSR, {src, dlt}, "modem_line_state");
    dlt = 4'h0;
  endtask

  initial begin
    rst_i      = 1'b1;
    pins_n     = 4'hF;
    rts_n      = 1'b1;
    line_err   = 1'b0;
    rx_timeout = 1'b0;
    rx_ready   = 1'b0;
    tx_low     = 1'b0;
    xoff_det   = 1'b0;
    src        = 4'h0;
    dlt        = 4'h0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'hB95C));
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    host.read_reg(ADDR_IER, 8'h00, "interrupt_enables");
    host.read_reg(ADDR_IIR, 8'h01, "interrupt_source_id");
    host.read_reg(ADDR_MSR, 8'h00, "modem_line_state");
    host.write_reg(ADDR_IER, 8'hFF);
    host.read_reg(ADDR_IER, 8'h0F, "interrupt_enables");
    host.write_reg(ADDR_EFR, 8'h10);
    host.write_reg(ADDR_IER, 8'hF0);
    host.read_reg(ADDR_IER, 8'hF0, "interrupt_enables");
    check("sleep_req_o", 8'h01, {7'h00, sleep_req});
    host.write_reg(ADDR_IIR, 8'h3C);
    host.write_reg(ADDR_FCR, 8'h01);
    host.read_reg(ADDR_IIR, 8'hC1, "interrupt_source_id");
    check("fifo_ctrl_o", 8'h01, fifo_ctrl);
    check("enh_feature_o", 8'h10, enh_feature);
    // Only the modem source enabled while the pins wander
    host.write_reg(ADDR_IER, 8'h08);
    repeat (12) modem_step(4'($urandom), 1'b0);
    modem_step(4'h0, 1'b0);
    // Loop bits match the idle pins, so the mode switch sets no change flag
    src = 4'hF;
    host.write_reg(ADDR_MCR, 8'h1F);
    repeat (3) @(posedge sys_clk_i);
    irq_expect(1'b0);
    check("modem_ctrl_o", 8'h1F, modem_ctrl);
    check("loopback_o", 8'h01, {7'h00, loopback});
    repeat (12) modem_step(4'($urandom), 1'b1);
    modem_step(4'hF, 1'b1);
    pins_n <= 4'hF;
    repeat (5) @(posedge sys_clk_i);
    host.write_reg(ADDR_MCR, 8'h00);
    src = 4'h0;
    modem_step(4'h0, 1'b0);
    // Every source at once, then peeled off in priority order
    @(posedge sys_clk_i);
    rts_n <= 1'b0;
    host.write_reg(ADDR_IER, 8'hEF);
    line_err   <= 1'b1;
    rx_timeout <= 1'b1;
    rx_ready   <= 1'b1;
    tx_low     <= 1'b1;
    rts_n      <= 1'b1;
    pins_n     <= 4'hE;
    xoff_det   <= 1'b1;
    @(posedge sys_clk_i);
    xoff_det <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    irq_expect(1'b1);
    id_expect(6'h06);
    line_err <= 1'b0;
    id_expect(6'h0C);
    rx_timeout <= 1'b0;
    id_expect(6'h04);
    rx_ready <= 1'b0;
    id_expect(6'h02);
    id_expect(6'h00);
    host.read_reg(ADDR_MSR, 8'h11, "modem_line_state");
    id_expect(6'h10);
    id_expect(6'h20);
    id_expect(6'h01);
    irq_expect(1'b0);
    // Tx below threshold stays quiet when its enable is toggled
    host.write_reg(ADDR_IER, 8'hED);
    host.write_reg(ADDR_IER, 8'hEF);
    id_expect(6'h01);
    irq_expect(1'b0);
    host.write_reg(ADDR_IER, 8'h00);
    line_err <= 1'b1;
    rx_ready <= 1'b1;
    id_expect(6'h01);
    irq_expect(1'b0);
    host.read_reg(ADDR_IER, 8'h00, "interrupt_enables");
    // Locked writes keep the protected control and fifo fields
    host.write_reg(ADDR_EFR, 8'h00);
    host.write_reg(ADDR_MCR, 8'hE0);
    host.write_reg(ADDR_FCR, 8'h31);
    host.read_reg(ADDR_MCR, 8'h00, "modem_control_reg");
    check("fifo_ctrl_o", 8'h01, fifo_ctrl);
    check("enh_feature_o", 8'h00, enh_feature);
    repeat (3) @(posedge sys_clk_i);
    test_done();
  end

  // Whole run is well under two thousand cycles
  initial begin
    #(40 * 20000);
    mismatches++;
    test_done();
  end
endmodule
